// ==== bench/pin_board.sv ====
// Board model of the eight port pins: keys, weak pull-ups and drive-back.
`timescale 1ns/1ps
`default_nettype none
module pin_board (
    input wire logic ref_clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] key_level,
    input wire logic [7:0] key_en,
    output logic [7:0] pin_in
);
    // A floating line must not read as a settled level, so it wanders.
    logic wander_q = 1'b0;
    always @(posedge ref_clk)
        wander_q <= ~wander_q;
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (!pin_oe_n[i])
                pin_in[i] = pin_out[i];
            else if (key_en[i])
                pin_in[i] = key_level[i];
            else if (pullup_on[i])
                pin_in[i] = 1'b1;
            else
                pin_in[i] = wander_q;
        end
    end
endmodule
`default_nettype wire

// ==== bench/port_b_gpio_chk.sv ====
// Concurrent checks on the ports of the general purpose port.
`timescale 1ns/1ps
`default_nettype none
module port_b_gpio_chk #(
    parameter WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [WIDTH-1:0] pin_oe_n,
    input wire logic [WIDTH-1:0] pullup_on,
    input wire logic ext_irq_zero,
    input wire logic low_voltage_prog_cfg,
    input wire logic prog_debug_active,
    input wire logic port_change_flag,
    input wire logic wake_request
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    a_one_wait_state:
    assert property (psel && penable && !pready |=> pready)
        else $error("access not answered after one wait state");
    a_ready_pulse:
    assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_error_answer:
    assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
        else $error("error answer without ready or with data");
    a_idle_data_zero:
    assert property (!pready |-> prdata == 32'h0)
        else $error("read data shown outside the answer cycle");
    a_upper_bits_zero:
    assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read data bits not zero");
    a_pullup_output_off:
    assert property (!(|(pullup_on & ~pin_oe_n)))
        else $error("pull-up on at a driven pin");
    a_wake_follows_flag:
    assert property (wake_request == port_change_flag)
        else $error("wake request differs from change flag");
    a_flag_clear_cause:
    assert property ($fell(port_change_flag) |->
        $past(psel && pwrite && paddr == 12'h00c && !pwdata[0]))
        else $error("change flag fell without a clearing write");
    a_irq_output_quiet:
    assert property ((!pin_oe_n[0])[*3] |-> !ext_irq_zero)
        else $error("external interrupt seen from an output pin");
    a_prog_entry_input:
    assert property (low_voltage_prog_cfg[*3] |-> pin_oe_n[5])
        else $error("programming entry pin driven");
    a_prog_clock_input:
    assert property (prog_debug_active[*3] |-> pin_oe_n[6])
        else $error("programming clock pin driven");
endmodule

bind port_b_gpio port_b_gpio_chk #(.WIDTH(WIDTH)) u_chk (.ref_clk, .rst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_oe_n, .pullup_on, .ext_irq_zero, .low_voltage_prog_cfg,
    .prog_debug_active, .port_change_flag, .wake_request);
`default_nettype wire

// ==== bench/test_port_b_gpio.sv ====
// Self-checking bench of the general purpose port.
`timescale 1ns/1ps
`default_nettype none
module test_port_b_gpio;
    typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [32:0] e;}
        row_t;
    logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, er, capture_compare_unit_two_capture_in, ext_irq_zero;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic ext_irq_one, ext_irq_two, pwm_fault_input, prog_entry_pin;
    logic prog_serial_clock, prog_serial_data_in, port_change_flag;
    logic wake_request, prog_data_out = 1'b0, prog_data_oe_n = 1'b1;
    logic analog_default_cfg = 1'b1, capture_pin_select_cfg = 1'b1;
    logic low_voltage_prog_cfg = 1'b0, prog_debug_active = 1'b0;
    logic capture_compare_unit_two_out = 1'b0, capture_compare_unit_two_out_valid = 1'b0;
    logic [7:0] pin_in, pin_out, pin_oe_n, pullup_on;
    logic [7:0] key_level = 8'h3c, key_en = 8'hff;
    logic [4:0] analog_select;
    int bad_count = 0, n_compared = 0;
    row_t rows[15] = '{
        '{1'b0, 12'h000, 32'h0, 33'h020},
        '{1'b0, 12'h008, 32'h0, 33'h0ff},
        '{1'b0, 12'h004, 32'h0, 33'h000},
        '{1'b0, 12'h010, 32'h0, 33'h080},
        '{1'b0, 12'h014, 32'h0, 33'h01f},
        '{1'b0, 12'h01c, 32'h0, 33'h100000000},
        '{1'b1, 12'h01c, 32'hff, 33'h100000000},
        '{1'b1, 12'h004, 32'ha5, 33'h0},
        '{1'b0, 12'h004, 32'h0, 33'h0a5},
        '{1'b1, 12'h008, 32'h0f, 33'h0},
        '{1'b0, 12'h008, 32'h0, 33'h00f},
        '{1'b1, 12'h014, 32'h0, 33'h0},
        '{1'b1, 12'h010, 32'h0, 33'h0},
        '{1'b0, 12'h010, 32'h0, 33'h000},
        '{1'b0, 12'h000, 32'h0, 33'h0ac}};

    port_b_gpio #(.WIDTH(8)) DUT (.ref_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out,
        .pin_oe_n, .pullup_on, .analog_select, .analog_default_cfg,
        .capture_pin_select_cfg, .low_voltage_prog_cfg, .prog_debug_active,
        .capture_compare_unit_two_out, .capture_compare_unit_two_out_valid, .capture_compare_unit_two_capture_in, .ext_irq_zero,
        .ext_irq_one, .ext_irq_two, .pwm_fault_input, .prog_entry_pin,
        .prog_serial_clock, .prog_data_out, .prog_data_oe_n,
        .prog_serial_data_in, .port_change_flag, .wake_request);
    pin_board u_board (.ref_clk, .pin_out, .pin_oe_n, .pullup_on, .key_level,
        .key_en, .pin_in);

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            bad_count++;
        end
    endtask
    // Sampling on the falling edge keeps checks clear of the updates.
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (3000) @(posedge ref_clk);
        bad_count++;
        report_and_stop;
    end
    initial
    begin
        tick(7);
        chk(pullup_on, 8'h0);
        chk(pin_oe_n, 8'hff);
        @(posedge ref_clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk({er, rows[i].w ? 32'h0 : rd}, rows[i].e);
        end
        chk(pin_out & 8'hf0, 8'ha0);
        chk(pullup_on, 8'h0f);
        @(posedge ref_clk);
        key_level <= 8'h3d;
        tick(5);
        chk(ext_irq_zero, 1'b1);
        chk(ext_irq_one, 1'b0);
        chk(ext_irq_two, 1'b1);
        $display("test done: registers and pins");
        apb(1'b1, 12'h008, 32'hf0);
        key_level <= 8'h00;
        tick(4);
        apb(1'b0, 12'h000, 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        tick(2);
        chk(port_change_flag, 1'b0);
        @(posedge ref_clk);
        key_level <= 8'h40;
        tick(6);
        chk(port_change_flag, 1'b1);
        apb(1'b1, 12'h00c, 32'h0);
        tick(2);
        chk(port_change_flag, 1'b1);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 8'h45);
        apb(1'b1, 12'h00c, 32'h0);
        tick(2);
        chk(port_change_flag, 1'b0);
        apb(1'b1, 12'h008, 32'h70);
        apb(1'b0, 12'h000, 32'h0);
        apb(1'b1, 12'h00c, 32'h0);
        apb(1'b1, 12'h004, 32'h25);
        tick(6);
        chk(port_change_flag, 1'b0);
        $display("test done: change detection");
        @(posedge ref_clk);
        capture_pin_select_cfg <= 1'b0;
        capture_compare_unit_two_out_valid <= 1'b1;
        capture_compare_unit_two_out <= 1'b1;
        apb(1'b1, 12'h018, 32'h3);
        tick(3);
        chk(pin_out[3], 1'b1);
        @(posedge ref_clk);
        low_voltage_prog_cfg <= 1'b1;
        prog_debug_active <= 1'b1;
        prog_data_oe_n <= 1'b0;
        prog_data_out <= 1'b1;
        key_level <= 8'h60;
        tick(5);
        chk(prog_entry_pin, 1'b1);
        chk(pin_oe_n[7:6], 2'b01);
        chk(pin_out[7], 1'b1);
        chk(prog_serial_clock, 1'b1);
        chk(prog_serial_data_in, 1'b1);
        chk(capture_compare_unit_two_capture_in, 1'b1);
        chk(pwm_fault_input, 1'b1);
        $display("test done: alternate functions");
        @(posedge ref_clk);
        low_voltage_prog_cfg <= 1'b0;
        prog_debug_active <= 1'b0;
        analog_default_cfg <= 1'b0;
        rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 5'h00);
        chk(analog_select, 5'h00);
        $display("test done: second reset");
        report_and_stop;
    end
endmodule
`default_nettype wire

// ==== core/change_detect.v ====
// Change detector comparing the upper input pins with a snapshot.
`timescale 1ns/1ps
`default_nettype none
module change_detect #(
    parameter WIDTH = 4
) (
    input wire ref_clk,
    input wire rst,
    input wire [WIDTH-1:0] pin_level,
    input wire [WIDTH-1:0] is_input,
    input wire snapshot_take,
    output reg mismatch
);
    reg [WIDTH-1:0] snap_q;
    wire [WIDTH-1:0] diff;

    // Only inputs take part; outputs are excluded per bit.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_cmp
            assign diff[i] = is_input[i] & (pin_level[i] ^ snap_q[i]);
        end
    endgenerate

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            snap_q <= {WIDTH{1'b0}};
            mismatch <= 1'b0;
        end
        else
        begin
            if (snapshot_take)
            begin
                snap_q <= pin_level;
                mismatch <= 1'b0;
            end
            else
            begin
                mismatch <= |diff;
            end
        end
    end
endmodule
`default_nettype wire

// ==== core/pin_sync.v ====
// Two-stage synchroniser for a bus of asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 8
) (
    input wire ref_clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== core/port_b_gpio.v ====
// Eight-pin general purpose port with change detection and APB registers.
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_port_defines.vh"

// Summary of operation
// - Eight pins, each with a direction bit; 1 makes it an input.
// - Direction 0 drives the pin from the output latch bit.
// - Output latch has its own address and reads back latch contents.
// - Clearing the pull-up control bit enables all weak pull-ups together.
// - A pin set as output never has its pull-up on.
// - Pull-ups are disabled after reset.
// - With analog default set, pins 4..0 start analog and read zero.
// - With analog default clear, pins 4..0 start as digital inputs.
// - Only the upper four input pins take part in change detection.
// - Input pins are compared with the snapshot; mismatches set the flag.
// - The change flag drives a wake request for sleep and idle modes.
// - Any port access refreshes the snapshot; software then clears flag.
// - A lasting mismatch keeps setting the flag against a clear.
// - With pin-select zero, pin 3 carries the capture/compare unit.
// - Low-voltage programming makes pin 5 the programming entry input; the port still reads it.
// - Serial programming or debug makes pins 6 and 7 clock and data.
// - Analog selection zeroes port reads of pins 4..0 only; interrupt, fault, capture, change inputs and output are untouched.
// - Pins 0..2 feed external interrupts; pin 0 also the fault input.
module port_b_gpio #(
    parameter WIDTH = 8
) (
    input wire ref_clk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out,
    output reg [WIDTH-1:0] pin_oe_n,
    output reg [WIDTH-1:0] pullup_on,
    output reg [4:0] analog_select,
    input wire analog_default_cfg,
    input wire capture_pin_select_cfg,
    input wire low_voltage_prog_cfg,
    input wire prog_debug_active,
    input wire capture_compare_unit_two_out,
    input wire capture_compare_unit_two_out_valid,
    output reg capture_compare_unit_two_capture_in,
    output reg ext_irq_zero,
    output reg ext_irq_one,
    output reg ext_irq_two,
    output reg pwm_fault_input,
    output reg prog_entry_pin,
    output reg prog_serial_clock,
    input wire prog_data_out,
    input wire prog_data_oe_n,
    output reg prog_serial_data_in,
    output reg port_change_flag,
    output reg wake_request
);
    // ****************************************************************
    // Registers and synchronised inputs
    // ****************************************************************
    reg [WIDTH-1:0] latch_q;
    reg [WIDTH-1:0] dir_q;
    reg pullup_n_q;
    reg [4:0] analog_q;
    reg fault_en_q;
    reg ccp_out_en_q;
    reg cfg_taken_q;
    reg flag_q;
    wire [WIDTH-1:0] pin_sync;
    wire [WIDTH-1:0] pin_digital;
    wire mismatch;
    wire acc;
    wire wr;
    wire rd;
    wire port_hit;
    wire mapped;
    reg [31:0] rdata_d;
    reg [WIDTH-1:0] out_d;
    reg [WIDTH-1:0] oe_n_d;
    reg [WIDTH-1:0] pu_d;
    integer k;

    pin_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // Analog pins read zero on the digital path; output is untouched.
    assign pin_digital = {pin_sync[WIDTH-1:`ANALOG_PINS],
        pin_sync[`ANALOG_PINS-1:0] & ~analog_q};

    // An access cycle is answered on the next clock: one wait state.
    assign acc = psel & penable & ~pready;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign port_hit = acc & (paddr == `ADDR_PIN_LEVEL_PORT);
    assign mapped = (paddr == `ADDR_PIN_LEVEL_PORT) ||
        (paddr == `ADDR_PIN_OUTPUT_LATCH) ||
        (paddr == `ADDR_PIN_DIRECTION) ||
        (paddr == `ADDR_IRQ_CONTROL_MAIN) ||
        (paddr == `ADDR_IRQ_CONTROL_SECOND) ||
        (paddr == `ADDR_ANALOG_CONFIG_REG) ||
        (paddr == `ADDR_PERIPH_CTRL);

    // ****************************************************************
    // Change detection
    // ****************************************************************
    change_detect #(
        .WIDTH(WIDTH - `CHANGE_LO)
    ) u_change (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_level(pin_sync[WIDTH-1:`CHANGE_LO]),
        .is_input(dir_q[WIDTH-1:`CHANGE_LO]),
        .snapshot_take(port_hit),
        .mismatch(mismatch)
    );

    // ****************************************************************
    // Register file
    // ****************************************************************
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            latch_q <= `RST_LATCH;
            dir_q <= `RST_DIRECTION;
            pullup_n_q <= 1'b1;
            analog_q <= `RST_ANALOG_ALL;
            fault_en_q <= 1'b0;
            ccp_out_en_q <= 1'b0;
            cfg_taken_q <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            // The strap is caught once after reset release.
            cfg_taken_q <= 1'b1;
            if (!cfg_taken_q)
            begin
                if (analog_default_cfg)
                begin
                    analog_q <= `RST_ANALOG_ALL;
                end
                else
                begin
                    analog_q <= `RST_ANALOG_NONE;
                end
            end
            if (wr)
            begin
                case (paddr)
                    `ADDR_PIN_LEVEL_PORT: latch_q <= pwdata[WIDTH-1:0];
                    `ADDR_PIN_OUTPUT_LATCH: latch_q <= pwdata[WIDTH-1:0];
                    `ADDR_PIN_DIRECTION: dir_q <= pwdata[WIDTH-1:0];
                    `ADDR_IRQ_CONTROL_SECOND:
                        pullup_n_q <= pwdata[`BIT_PULLUP_ENABLE_N];
                    `ADDR_ANALOG_CONFIG_REG:
                        analog_q <= pwdata[`ANALOG_PINS-1:0];
                    `ADDR_PERIPH_CTRL:
                    begin
                        fault_en_q <= pwdata[`BIT_FAULT_ENABLE];
                        ccp_out_en_q <= pwdata[`BIT_CAPTURE_OUT_EN];
                    end
                    default:
                    begin
                    end
                endcase
            end
            // A mismatch sets the flag and wins over a software clear.
            if (mismatch)
            begin
                flag_q <= 1'b1;
            end
            else if (wr && paddr == `ADDR_IRQ_CONTROL_MAIN &&
                !pwdata[`BIT_PORT_CHANGE_FLAG])
            begin
                flag_q <= 1'b0;
            end
        end
    end

    always @*
    begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `ADDR_PIN_LEVEL_PORT: rdata_d[WIDTH-1:0] = pin_digital;
            `ADDR_PIN_OUTPUT_LATCH: rdata_d[WIDTH-1:0] = latch_q;
            `ADDR_PIN_DIRECTION: rdata_d[WIDTH-1:0] = dir_q;
            `ADDR_IRQ_CONTROL_MAIN: rdata_d[`BIT_PORT_CHANGE_FLAG] = flag_q;
            `ADDR_IRQ_CONTROL_SECOND: rdata_d[`BIT_PULLUP_ENABLE_N] = pullup_n_q;
            `ADDR_ANALOG_CONFIG_REG: rdata_d[`ANALOG_PINS-1:0] = analog_q;
            `ADDR_PERIPH_CTRL:
            begin
                rdata_d[`BIT_FAULT_ENABLE] = fault_en_q;
                rdata_d[`BIT_CAPTURE_OUT_EN] = ccp_out_en_q;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // ****************************************************************
    // Pin drivers
    // ****************************************************************
    always @*
    begin
        out_d = latch_q;
        oe_n_d = dir_q;
        pu_d = {WIDTH{1'b0}};
        for (k = 0; k < WIDTH; k = k + 1)
        begin
            pu_d[k] = ~pullup_n_q & dir_q[k];
        end
        // Compare output takes priority over port data on pin 3.
        if (!capture_pin_select_cfg && ccp_out_en_q && capture_compare_unit_two_out_valid)
        begin
            out_d[`PIN_CAPTURE] = capture_compare_unit_two_out;
            oe_n_d[`PIN_CAPTURE] = 1'b0;
            // The unit drives the pin, so its pull-up must go off too.
            pu_d[`PIN_CAPTURE] = 1'b0;
        end
        if (low_voltage_prog_cfg)
        begin
            oe_n_d[`PIN_PROG_ENTRY] = 1'b1;
            pu_d[`PIN_PROG_ENTRY] = 1'b0;
        end
        if (prog_debug_active)
        begin
            oe_n_d[`PIN_PROG_CLOCK] = 1'b1;
            pu_d[`PIN_PROG_CLOCK] = 1'b0;
            out_d[`PIN_PROG_DATA] = prog_data_out;
            oe_n_d[`PIN_PROG_DATA] = prog_data_oe_n;
            pu_d[`PIN_PROG_DATA] = 1'b0;
        end
    end

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            pin_out <= `RST_LATCH;
            pin_oe_n <= `RST_DIRECTION;
            pullup_on <= {WIDTH{1'b0}};
            analog_select <= `RST_ANALOG_ALL;
            capture_compare_unit_two_capture_in <= 1'b0;
            ext_irq_zero <= 1'b0;
            ext_irq_one <= 1'b0;
            ext_irq_two <= 1'b0;
            pwm_fault_input <= 1'b0;
            prog_entry_pin <= 1'b0;
            prog_serial_clock <= 1'b0;
            prog_serial_data_in <= 1'b0;
            port_change_flag <= 1'b0;
            wake_request <= 1'b0;
        end
        else
        begin
            pready <= acc;
            pslverr <= acc & ~mapped;
            prdata <= rd ? rdata_d : 32'h0000_0000;
            pin_out <= out_d;
            pin_oe_n <= oe_n_d;
            pullup_on <= pu_d;
            analog_select <= analog_q;
            capture_compare_unit_two_capture_in <= ~capture_pin_select_cfg &
                pin_sync[`PIN_CAPTURE];
            // Only input pins feed the external interrupts.
            ext_irq_zero <= dir_q[0] & pin_sync[0];
            ext_irq_one <= dir_q[1] & pin_sync[1];
            ext_irq_two <= dir_q[2] & pin_sync[2];
            pwm_fault_input <= fault_en_q & pin_sync[`PIN_FAULT];
            prog_entry_pin <= low_voltage_prog_cfg &
                pin_sync[`PIN_PROG_ENTRY];
            prog_serial_clock <= prog_debug_active &
                pin_sync[`PIN_PROG_CLOCK];
            prog_serial_data_in <= prog_debug_active &
                pin_sync[`PIN_PROG_DATA];
            port_change_flag <= flag_q;
            // Wake works in any power mode since it needs no gated clock.
            wake_request <= flag_q;
        end
    end
endmodule
`default_nettype wire

// ==== shared/gpio_port_defines.vh ====
// Register map, field positions and reset values of the general purpose port.
`ifndef GPIO_PORT_DEFINES_VH
`define GPIO_PORT_DEFINES_VH

// ********************************************************************
// Register byte addresses
// ********************************************************************
`define ADDR_PIN_LEVEL_PORT 12'h000
`define ADDR_PIN_OUTPUT_LATCH 12'h004
`define ADDR_PIN_DIRECTION 12'h008
`define ADDR_IRQ_CONTROL_MAIN 12'h00c
`define ADDR_IRQ_CONTROL_SECOND 12'h010
`define ADDR_ANALOG_CONFIG_REG 12'h014
`define ADDR_PERIPH_CTRL 12'h018
`define ADDR_WIDTH 12

// ********************************************************************
// Field positions
// ********************************************************************
`define BIT_PORT_CHANGE_FLAG 0
`define BIT_PULLUP_ENABLE_N 7
`define BIT_FAULT_ENABLE 0
`define BIT_CAPTURE_OUT_EN 1
`define ANALOG_PINS 5
`define CHANGE_LO 4
`define PIN_CAPTURE 3
`define PIN_PROG_ENTRY 5
`define PIN_PROG_CLOCK 6
`define PIN_PROG_DATA 7
`define PIN_FAULT 0

// ********************************************************************
// Reset values
// ********************************************************************
`define RST_LATCH 8'h00
`define RST_DIRECTION 8'hff
`define RST_IRQ_SECOND 8'h80
`define RST_ANALOG_ALL 5'h1f
`define RST_ANALOG_NONE 5'h00

`endif
